// ===== include/tdc_regs.svh
// Coprocessor selectors, command codes, masks, reset values and counts
// Assumes inclusion by the design files of the TCM DMA channel block
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH

// Register selectors on the coprocessor access port
`define TDC_CRM_ID 4'h0
`define TDC_CRM_UACC 4'h1
`define TDC_CRM_CHNUM 4'h2
`define TDC_CRM_CMD 4'h3
`define TDC_CRM_CTRL 4'h4
`define TDC_CRM_ISTART 4'h5
`define TDC_CRM_ESTART 4'h6
`define TDC_CRM_IEND 4'h7
`define TDC_CRM_STAT 4'h8
`define TDC_CRM_CTX 4'hf

// Operation selector values of the command register
`define TDC_OP_STOP 3'h0
`define TDC_OP_START 3'h1
`define TDC_OP_CLEAR 3'h2

// Identification and status views
`define TDC_ID_PRESENT 3'h0
`define TDC_ID_QUEUED 3'h1
`define TDC_ID_RUNNING 3'h2
`define TDC_ID_IRQ 3'h3

// Control register: writable bits and reset value
`define TDC_CTRL_MASK 32'hfc0f_ff03
`define TDC_CTRL_RST 32'h0000_0000
`define TDC_WORD_RST 32'h0000_0000

// External abort code of the status error field
`define TDC_ES_ABORT 5'h1a
`define TDC_ES_NONE 5'h00

// Written-location tracking: 16-byte groups, 64 of them
`define TDC_GRP_LSB 4
`define TDC_GRP_BITS 6
`define TDC_CHANNELS 2

`endif

// ===== include/tdc_pkg.sv
// Types shared by the TCM DMA channel control block
// Assumes the constants header is included by each design file
package tdc_pkg;

  // Status codes follow declaration order: idle, queued, running, done
  typedef enum logic [1:0] {st_idle, st_queued, st_running, st_done} tdc_stat_t;

  typedef enum logic {e_idle, e_wait} tdc_eng_t;

  typedef struct packed {
    logic target_tcm_select;
    logic transfer_direction;
    logic irq_on_done;
    logic irq_on_fault;
    logic full_transfer;
    logic user_perm_check;
    logic [5:0] rsvd_hi;
    logic [11:0] external_stride;
    logic [5:0] rsvd_lo;
    logic [1:0] access_size;
  } tdc_ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    logic [3:0] coproc_reg_selector;
    logic [2:0] op2;
    logic [31:0] wdata;
  } tdc_cp_req_t;

  typedef struct packed {
    logic [31:0] ext_addr;
    logic [31:0] int_addr;
    logic [1:0] size;
    logic dir;
    logic itcm;
    logic user;
  } tdc_xfer_t;

endpackage

// ===== src/tdc_dirty.sv
// Record of written data TCM groups, one bit per aligned four-word group
// Assumes stores and DMA touches arrive on the processor clock
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_dirty (
  input logic clk,
  input logic rst_b,
  input logic set_en,
  input logic [`TDC_GRP_BITS-1:0] set_grp,
  input logic clr_en,
  input logic [`TDC_GRP_BITS-1:0] clr_grp,
  input logic [`TDC_GRP_BITS-1:0] grp,
  output logic dirty
);

  logic [(1<<`TDC_GRP_BITS)-1:0] map;
  logic [(1<<`TDC_GRP_BITS)-1:0] next_map;

  // A store in the same cycle as a DMA touch wins, so no write is lost
  always_comb begin
    next_map = map;
    if (clr_en) begin
      next_map[clr_grp] = 1'b0;
    end
    if (set_en) begin
      next_map[set_grp] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map <= '0;
    end else begin
      map <= next_map;
    end
  end

  assign dirty = map[grp];

endmodule

// ===== src/tdc_chan.sv
// Per-channel registers and status sequencing of the TCM DMA
// Assumes the parent decodes access rights and runs the shared engine
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_chan
  import tdc_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input logic wr_ctrl,
  input logic wr_ctx,
  input logic wr_ist,
  input logic wr_est,
  input logic wr_iend,
  input logic [31:0] wdata,
  input logic cmd_en,
  input logic [2:0] cmd_op,
  input logic cmd_user,
  input logic u_bit,
  input logic other_busy,
  input logic eng_step,
  input logic [31:0] eng_int,
  input logic [31:0] eng_ext,
  input logic eng_done,
  input logic eng_err,
  input logic eng_stop,
  output tdc_ctrl_t ctrl,
  output logic [31:0] ctx,
  output logic [31:0] ist,
  output logic [31:0] est,
  output logic [31:0] iend,
  output tdc_stat_t state,
  output logic [4:0] err_code,
  output logic irq,
  output logic stop_req,
  output logic start_user,
  output logic in_op
);

  tdc_stat_t next_state;
  wire locked = (state == st_queued) || (state == st_running);
  wire start = cmd_en && (cmd_op == `TDC_OP_START) && (state == st_idle);
  wire stop = cmd_en && (cmd_op == `TDC_OP_STOP);
  wire clear = cmd_en && (cmd_op == `TDC_OP_CLEAR) && (state == st_done);
  wire set_irq = (eng_done && ctrl.irq_on_done)
              || (eng_err && (ctrl.irq_on_fault || u_bit));

  // A failed channel still counts as busy for the other one's Start
  assign in_op = locked || ((state == st_done) && (err_code != `TDC_ES_NONE));

  //----------------------------------------------------------------
  // Status sequencing
  //----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (start) begin
          next_state = other_busy ? st_queued : st_running;
        end
      end
      st_queued: begin
        if (stop) begin
          next_state = st_idle;
        end else if (!other_busy) begin
          next_state = st_running;
        end
      end
      st_running: begin
        if (eng_stop) begin
          next_state = st_idle;
        end else if (eng_done || eng_err) begin
          next_state = st_done;
        end
      end
      st_done: begin
        if (clear) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      stop_req <= 1'b0;
      start_user <= 1'b0;
      err_code <= `TDC_ES_NONE;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      stop_req <= (state == st_running) && (stop_req || stop) && !eng_stop;
      if (start) begin
        start_user <= cmd_user;
        err_code <= `TDC_ES_NONE;
      end else if (eng_err) begin
        err_code <= `TDC_ES_ABORT;
      end
      // Level until Clear; set and clear never meet in one state
      irq <= set_irq || (irq && !clear);
    end
  end

  //----------------------------------------------------------------
  // Programmed registers
  //----------------------------------------------------------------
  // Address writes while busy are dropped; the engine owns them then
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `TDC_CTRL_RST;
      ctx <= `TDC_WORD_RST;
      ist <= `TDC_WORD_RST;
      est <= `TDC_WORD_RST;
      iend <= `TDC_WORD_RST;
    end else begin
      if (wr_ctrl) ctrl <= wdata & `TDC_CTRL_MASK;
      if (wr_ctx && !locked) ctx <= wdata;
      if (wr_iend && !locked) iend <= wdata;
      if (eng_step) begin
        ist <= eng_int;
        est <= eng_ext;
      end else begin
        if (wr_ist && !locked) ist <= wdata;
        if (wr_est && !locked) est <= wdata;
      end
    end
  end

endmodule

// ===== src/tdc_dma_ctrl.sv
// TCM DMA channel control: coprocessor register file and shared engine
// Assumes memory system and TCM store reports run on the same clock
//
// Behaviour
// - Each channel has a privileged read/write context tag at selector 15.
// - Context tag writes are ignored while the channel is Running or Queued.
// - Low eight context bits drive the space identifier toward memory.
// - User-mode access to the context tag traps as undefined.
// - User access to control traps when the channel's user bit is clear.
// - Bit 31 picks instruction or data TCM, bit 30 the direction.
// - Bit 29 raises the interrupt on completion until Clear.
// - Errors interrupt when bit 28 or the user bit is set.
// - Outbound data with bit 27 clear moves at least all written groups.
// - Full transfer moves every location and leaves the written record.
// - Written tracking uses aligned four-word groups moved whole.
// - Full-transfer bit has no effect on instruction TCM transfers.
// - Bit 26 or a user-mode starter makes transfers checked as user.
// - Bits 19:8 add a byte stride to the external address.
// - Internal address steps by the transaction size every access.
// - Bits 1:0 give access size, issued exactly as programmed.
// - Selector 3 takes write-only commands: 0 stops, 1 starts.
// - Start enters Running unless the other channel is in operation.
// - Stop waits for outstanding accesses when Running, is instant when Queued.
// - Command 2 clears Complete-or-Error to Idle and drops the interrupt.
// - Status code: 00 idle, 01 queued, 10 running, 11 done.
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_dma_ctrl
  import tdc_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input tdc_cp_req_t cp_req,
  output logic [31:0] cp_rdata,
  output logic cp_undef,
  output tdc_xfer_t xfer,
  output logic ext_req,
  output logic [7:0] space_id_out,
  input logic ext_done,
  input logic ext_err,
  input logic tcm_store,
  input logic [31:0] tcm_store_addr,
  output logic [1:0] irq
);

  localparam int NCH = `TDC_CHANNELS;

  logic chnum;
  logic [1:0] u_acc;
  tdc_eng_t e_st;
  tdc_eng_t next_e;
  logic [31:0] rd;
  logic [1:0] id_bits;

  tdc_ctrl_t ctrl_a [NCH];
  logic [31:0] ctx_a [NCH];
  logic [31:0] ist_a [NCH];
  logic [31:0] est_a [NCH];
  logic [31:0] iend_a [NCH];
  tdc_stat_t st_a [NCH];
  logic [4:0] es_a [NCH];
  logic [NCH-1:0] stop_req;
  logic [NCH-1:0] start_user;
  logic [NCH-1:0] in_op;
  logic [NCH-1:0] q_v;
  logic [NCH-1:0] r_v;

  //----------------------------------------------------------------
  // Access rights
  //----------------------------------------------------------------
  // Trap decisions are combinational so the core sees them in the cycle
  wire [3:0] coproc_reg_selector = cp_req.coproc_reg_selector;
  wire usr = cp_req.valid && cp_req.user;
  wire crm_chan = (coproc_reg_selector >= `TDC_CRM_CMD) && (coproc_reg_selector <= `TDC_CRM_STAT);
  wire trap_priv = (coproc_reg_selector == `TDC_CRM_ID) || (coproc_reg_selector == `TDC_CRM_UACC)
                || (coproc_reg_selector == `TDC_CRM_CTX);
  wire trap_chan = crm_chan && !u_acc[chnum];
  wire trap_num = (coproc_reg_selector == `TDC_CRM_CHNUM) && (u_acc == 2'b00);
  assign cp_undef = usr && (trap_priv || trap_chan || trap_num);

  wire ok = cp_req.valid && !cp_undef;
  wire wr = ok && cp_req.write;
  wire rd_en = ok && !cp_req.write;

  //----------------------------------------------------------------
  // Global registers
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chnum <= 1'b0;
      u_acc <= 2'b00;
    end else begin
      if (wr && (coproc_reg_selector == `TDC_CRM_CHNUM)) chnum <= cp_req.wdata[0];
      if (wr && (coproc_reg_selector == `TDC_CRM_UACC)) u_acc <= cp_req.wdata[1:0];
    end
  end

  //----------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------
  always_comb begin
    case (cp_req.op2)
      `TDC_ID_PRESENT: id_bits = 2'b11;
      `TDC_ID_QUEUED: id_bits = q_v;
      `TDC_ID_RUNNING: id_bits = r_v;
      `TDC_ID_IRQ: id_bits = irq;
      default: id_bits = 2'b00;
    endcase
  end

  // Write-only and reserved selectors read as zero
  always_comb begin
    case (coproc_reg_selector)
      `TDC_CRM_ID: rd = {30'h0, id_bits};
      `TDC_CRM_UACC: rd = {30'h0, u_acc};
      `TDC_CRM_CHNUM: rd = {31'h0, chnum};
      `TDC_CRM_CTRL: rd = ctrl_a[chnum];
      `TDC_CRM_ISTART: rd = ist_a[chnum];
      `TDC_CRM_ESTART: rd = est_a[chnum];
      `TDC_CRM_IEND: rd = iend_a[chnum];
      `TDC_CRM_STAT: rd = {19'h0, 1'b0, es_a[chnum], 5'h0, st_a[chnum]};
      `TDC_CRM_CTX: rd = ctx_a[chnum];
      default: rd = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cp_rdata <= 32'h0;
    end else if (rd_en) begin
      cp_rdata <= rd;
    end
  end

  //----------------------------------------------------------------
  // Shared transfer engine
  //----------------------------------------------------------------
  // Only one channel runs at a time, so one engine serves both
  wire act = (st_a[1] == st_running);
  wire run = st_a[act] == st_running;
  tdc_ctrl_t c;
  assign c = ctrl_a[act];
  wire idle_run = run && (e_st == e_idle);

  wire [31:0] step_sz = 32'h1 << c.access_size;
  wire [31:0] next_int = ist_a[act] + step_sz;
  wire [31:0] next_ext = est_a[act] + {20'h0, c.external_stride};
  wire at_end = ist_a[act] == iend_a[act];

  // Tracking applies only to data TCM with full transfer clear
  wire track = !c.target_tcm_select && !c.full_transfer;
  wire grp_dirty;
  // Group of the last good tracked access; the rest of that group still moves
  logic moved_v;
  logic [`TDC_GRP_BITS-1:0] moved_grp;
  wire [`TDC_GRP_BITS-1:0] cur_grp = ist_a[act][`TDC_GRP_LSB +: `TDC_GRP_BITS];
  wire in_moved = moved_v && (moved_grp == cur_grp);
  wire skip = track && c.transfer_direction && !grp_dirty && !in_moved;

  wire eng_stop = idle_run && stop_req[act];
  wire eng_done = idle_run && !stop_req[act] && at_end;
  wire go = idle_run && !stop_req[act] && !at_end;
  wire fin = (e_st == e_wait) && ext_done;
  wire eng_err = fin && ext_err;
  wire eng_step = (go && skip) || (fin && !ext_err);
  wire issue = go && !skip;
  wire xuser = c.user_perm_check || start_user[act];

  // Clearing the record on each completed touch keeps stores after the group's
  // last touch recorded, while this flag still moves the group's remaining words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      moved_v <= 1'b0;
      moved_grp <= '0;
    end else if (!run) begin
      moved_v <= 1'b0;
    end else if (fin && !ext_err && track) begin
      moved_v <= 1'b1;
      moved_grp <= cur_grp;
    end
  end

  tdc_xfer_t next_xfer;
  assign next_xfer = '{
    ext_addr: est_a[act],
    int_addr: ist_a[act],
    size: c.access_size,
    dir: c.transfer_direction,
    itcm: c.target_tcm_select,
    user: xuser
  };

  always_comb begin
    case (e_st)
      e_idle: next_e = issue ? e_wait : e_idle;
      e_wait: next_e = ext_done ? e_idle : e_wait;
      default: next_e = e_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      e_st <= e_idle;
      xfer <= '0;
      space_id_out <= 8'h00;
    end else begin
      e_st <= next_e;
      if (issue) begin
        xfer <= next_xfer;
        space_id_out <= ctx_a[act][7:0];
      end
    end
  end

  assign ext_req = (e_st == e_wait);

  //----------------------------------------------------------------
  // Written-group record and channels
  //----------------------------------------------------------------
  // A completed touch with tracking on forgets the group
  tdc_dirty u_dirty (
    .clk(clk),
    .rst_b(rst_b),
    .set_en(tcm_store),
    .set_grp(tcm_store_addr[`TDC_GRP_LSB +: `TDC_GRP_BITS]),
    .clr_en(fin && !ext_err && track),
    .clr_grp(ist_a[act][`TDC_GRP_LSB +: `TDC_GRP_BITS]),
    .grp(ist_a[act][`TDC_GRP_LSB +: `TDC_GRP_BITS]),
    .dirty(grp_dirty)
  );

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire sel = chnum == 1'(i);
    wire me = act == 1'(i);
    wire wr_ch = wr && sel;
    assign q_v[i] = st_a[i] == st_queued;
    assign r_v[i] = st_a[i] == st_running;
    tdc_chan u_ch (
      .clk(clk),
      .rst_b(rst_b),
      .wr_ctrl(wr_ch && (coproc_reg_selector == `TDC_CRM_CTRL)),
      .wr_ctx(wr_ch && (coproc_reg_selector == `TDC_CRM_CTX)),
      .wr_ist(wr_ch && (coproc_reg_selector == `TDC_CRM_ISTART)),
      .wr_est(wr_ch && (coproc_reg_selector == `TDC_CRM_ESTART)),
      .wr_iend(wr_ch && (coproc_reg_selector == `TDC_CRM_IEND)),
      .wdata(cp_req.wdata),
      .cmd_en(wr_ch && (coproc_reg_selector == `TDC_CRM_CMD)),
      .cmd_op(cp_req.op2),
      .cmd_user(cp_req.user),
      .u_bit(u_acc[i]),
      .other_busy(in_op[NCH-1-i]),
      .eng_step(eng_step && me),
      .eng_int(next_int),
      .eng_ext(next_ext),
      .eng_done(eng_done && me),
      .eng_err(eng_err && me),
      .eng_stop(eng_stop && me),
      .ctrl(ctrl_a[i]),
      .ctx(ctx_a[i]),
      .ist(ist_a[i]),
      .est(est_a[i]),
      .iend(iend_a[i]),
      .state(st_a[i]),
      .err_code(es_a[i]),
      .irq(irq[i]),
      .stop_req(stop_req[i]),
      .start_user(start_user[i]),
      .in_op(in_op[i])
    );
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire cmd0 = wr && !chnum && (coproc_reg_selector == `TDC_CRM_CMD);
  // Channel 1 is the one that gets queued behind a running channel 0
  wire cmd1 = wr && chnum && (coproc_reg_selector == `TDC_CRM_CMD);
  wire clr0 = cmd0 && (cp_req.op2 == `TDC_OP_CLEAR) && (st_a[0] == st_done);

  sequence s_start1_busy;
    cmd1 && (cp_req.op2 == `TDC_OP_START) && (st_a[1] == st_idle) && in_op[0];
  endsequence

  sequence s_finish0;
    eng_done && !act && ctrl_a[0].irq_on_done;
  endsequence

  a_ctx_user_trap: assert property (
    usr && (coproc_reg_selector == `TDC_CRM_CTX) |-> cp_undef)
    else $error("User context tag access not trapped");

  a_ctx_write_lock: assert property (
    wr && !chnum && (coproc_reg_selector == `TDC_CRM_CTX) && in_op[0] && (st_a[0] != st_done)
    |=> $stable(ctx_a[0]))
    else $error("Context tag changed while busy");

  a_asid_match: assert property (
    ext_req |-> space_id_out == ctx_a[act][7:0])
    else $error("Space identifier differs from context tag");

  a_size_exact: assert property (
    ext_req |-> xfer.size == ctrl_a[act].access_size)
    else $error("Access size differs from control");

  a_user_check: assert property (
    ext_req && (start_user[act] || ctrl_a[act].user_perm_check) |-> xfer.user)
    else $error("Transfer not checked as user");

  a_int_advance: assert property (
    eng_step && !act |=> ist_a[0] == $past(next_int))
    else $error("Internal address step wrong");

  a_ext_stride: assert property (
    eng_step && !act |=> est_a[0] == $past(est_a[0]) + {20'h0, $past(c.external_stride)})
    else $error("External address stride wrong");

  a_irq_hold: assert property (
    irq[0] && !clr0 |=> irq[0])
    else $error("Interrupt dropped without Clear");

  a_done_irq: assert property (
    s_finish0 |=> irq[0] && (st_a[0] == st_done))
    else $error("Completion interrupt missing");

  a_start_queue: assert property (
    s_start1_busy |=> st_a[1] == st_queued)
    else $error("Start with busy peer did not queue");

  a_stop_queued: assert property (
    cmd1 && (cp_req.op2 == `TDC_OP_STOP) && (st_a[1] == st_queued) |=> st_a[1] == st_idle)
    else $error("Stop while queued did not idle");

  a_rsvd_zero: assert property (
    (ctrl_a[0] & ~`TDC_CTRL_MASK) == 32'h0)
    else $error("Reserved control bits set");

endmodule

// ===== bench/tdc_mem_model.sv
// Level-two memory model that answers the DMA engine's external accesses
// Assumes requests are launched from flops on the rising edge of clk
`timescale 1ns/100ps
module tdc_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_req,
  input wire logic [3:0] delay,
  input wire logic fail,
  output logic ext_done,
  output logic ext_err
);
  // ----------------------------------------
  // Reply timing
  // ----------------------------------------
  logic [3:0] cnt;

  // Replies after delay cycles; the error line toggles when unqualified so that
  // a design reading it outside a reply never sees a steady, plausible level
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_done <= 1'b0;
      ext_err <= 1'b0;
      cnt <= 4'h0;
    end else if (ext_req && !ext_done && cnt >= delay) begin
      ext_done <= 1'b1;
      ext_err <= fail;
      cnt <= 4'h0;
    end else begin
      ext_done <= 1'b0;
      ext_err <= ~ext_err;
      cnt <= ext_req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== bench/tdc_dma_ctrl_tb.sv
// Self-checking bench for the TCM DMA channel control block
// Assumes the memory model and the design files are compiled before it
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_dma_ctrl_tb
  import tdc_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst_b, tcm_store, ext_done, ext_err, ext_req, cp_undef, fail, undef;
  logic [31:0] cp_rdata, tcm_store_addr, rd, r, m_ist, m_est, m_ctx, exp_int;
  logic [7:0] space_id_out;
  logic [1:0] irq, m_sz;
  logic [3:0] delay;
  logic [11:0] m_str;
  logic m_dir, m_itcm, m_user;
  tdc_cp_req_t cp_req;
  tdc_xfer_t xfer;
  int fails, total_checks, nacc;
  int d_st [5] = '{'h124, 0, 'h108, 0, 0};
  int d_f [5] = '{'h10, 'h10, 'h12, 'h10, 'h30};
  int d_o [5] = '{'h20, 0, 0, 0, 0};
  int d_n [5] = '{4, 0, 16, 4, 16};

  tdc_dma_ctrl uut (.clk(clk), .rst_b(rst_b), .cp_req(cp_req), .cp_rdata(cp_rdata),
    .cp_undef(cp_undef), .xfer(xfer), .ext_req(ext_req), .space_id_out(space_id_out),
    .ext_done(ext_done), .ext_err(ext_err), .tcm_store(tcm_store),
    .tcm_store_addr(tcm_store_addr), .irq(irq));
  tdc_mem_model mem (.clk(clk), .rst_b(rst_b), .ext_req(ext_req), .delay(delay),
    .fail(fail), .ext_done(ext_done), .ext_err(ext_err));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One access: held from a falling edge through the taking rising edge
  task cp(input logic w, input logic u, input logic [3:0] coproc_reg_selector, input logic [2:0] op,
      input logic [31:0] d);
    @(negedge clk);
    cp_req = '{1'b1, w, u, coproc_reg_selector, op, d};
    #1 undef = cp_undef;
    @(negedge clk);
    cp_req.valid = 1'b0;
    rd = cp_rdata;
  endtask

  task wr(input logic [3:0] coproc_reg_selector, input logic [31:0] d);
    cp(1'b1, 1'b0, coproc_reg_selector, 3'h0, d);
  endtask

  task rdr(input logic [3:0] coproc_reg_selector);
    cp(1'b0, 1'b0, coproc_reg_selector, 3'h0, 32'h0);
  endtask

  task cmd(input logic [2:0] op, input logic u);
    cp(1'b1, u, `TDC_CRM_CMD, op, 32'h0);
  endtask

  // Polls status, bounded so a stuck channel shows up as a mismatch later
  task wait_st(input logic [1:0] s);
    rdr(`TDC_CRM_STAT);
    for (int i = 0; i < 300 && rd[1:0] !== s; i++)
      rdr(`TDC_CRM_STAT);
  endtask

  task store(input logic [31:0] a);
    @(negedge clk);
    tcm_store = 1'b1;
    tcm_store_addr = a;
    @(negedge clk);
    tcm_store = 1'b0;
    tcm_store_addr = ~a;
  endtask

  // Programs the selected channel, with the context loaded first as setup demands
  task run(input logic [5:0] f, input logic [11:0] s, input logic [1:0] z, input int n,
      input logic u, input logic [31:0] o);
    m_ist = 32'h100;
    m_est = $urandom & 32'hffff_0ff8;
    m_ctx = $urandom;
    m_str = s;
    m_sz = z;
    m_itcm = f[5];
    m_dir = f[4];
    m_user = f[0] | u;
    exp_int = m_ist + o;
    nacc = 0;
    wr(`TDC_CRM_CTX, m_ctx);
    wr(`TDC_CRM_CTRL, {f, 6'h0, s, 6'h0, z});
    wr(`TDC_CRM_ISTART, m_ist);
    wr(`TDC_CRM_IEND, m_ist + (n << z));
    wr(`TDC_CRM_ESTART, m_est);
    cmd(`TDC_OP_START, u);
  endtask

  task fin(input string name, input int n, input logic [1:0] ei);
    wait_st(2'b11);
    chk(name, n, nacc);
    chk("irq", ei, irq);
    cmd(`TDC_OP_CLEAR, 1'b0);
  endtask

  // Each finished external access against the programmed geometry
  always @(posedge clk) begin
    if (ext_req && ext_done) begin
      nacc++;
      chk("int_addr", exp_int, xfer.int_addr);
      chk("ext_addr", m_est + ((xfer.int_addr - m_ist) >> m_sz) * m_str, xfer.ext_addr);
      chk("attrs", {m_sz, m_dir, m_itcm, m_user}, {xfer.size, xfer.dir, xfer.itcm, xfer.user});
      chk("space_id", m_ctx[7:0], space_id_out);
      exp_int = exp_int + (32'h1 << m_sz);
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hc3547950));
    rst_b = 1'b0;
    cp_req = '0;
    tcm_store = 1'b0;
    tcm_store_addr = 32'h0;
    delay = 4'h0;
    fail = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rdr(`TDC_CRM_CTRL);
    chk("ctrl_rst", 0, rd);
    rdr(`TDC_CRM_STAT);
    chk("stat_rst", 0, rd);
    r = $urandom;
    wr(`TDC_CRM_CTX, r);
    rdr(`TDC_CRM_CTX);
    chk("ctx_rw", r, rd);
    cp(1'b0, 1'b1, `TDC_CRM_CTX, 3'h0, 32'h0);
    chk("ctx_user_rd", 1, undef);
    cp(1'b1, 1'b1, `TDC_CRM_CTX, 3'h0, 32'h0);
    chk("ctx_user_wr", 1, undef);
    cp(1'b1, 1'b1, `TDC_CRM_CTRL, 3'h0, 32'h0);
    chk("ctrl_user", 1, undef);
    r = $urandom | 32'h03f0_00fc;
    wr(`TDC_CRM_CTRL, r);
    rdr(`TDC_CRM_CTRL);
    chk("ctrl_mask", r & `TDC_CTRL_MASK, rd);
    $display("test registers done");
    // Every access size, stride zero at byte size
    for (int z = 0; z < 4; z++) begin
      run(6'h08, 12'(z == 0 ? 0 : ($urandom % 4) << z), 2'(z), 3, 1'b0, 0);
      fin("size_acc", 3, 2'h1);
      rdr(`TDC_CRM_STAT);
      chk("clear", 0, {irq, rd[1:0]});
    end
    $display("test sizes done");
    // Error reporting with the fault bit, the user bit, and neither
    fail = 1'b1;
    for (int j = 0; j < 3; j++) begin
      wr(`TDC_CRM_UACC, 32'(j == 1));
      run({3'h0, j == 0, 2'h0}, 12'h0, 2'h2, 2, j == 1, 0);
      wait_st(2'b11);
      chk("err_stat", {`TDC_ES_ABORT, 7'h03}, rd[11:0]);
      fin("err_acc", 1, 2'(j < 2));
    end
    fail = 1'b0;
    $display("test errors done");
    // Queue behind a slow running channel, then stop both
    delay = 4'hf;
    run(6'h00, 12'h4, 2'h2, 4, 1'b0, 0);
    wr(`TDC_CRM_CTX, ~m_ctx);
    wr(`TDC_CRM_CHNUM, 32'h1);
    cmd(`TDC_OP_START, 1'b0);
    rdr(`TDC_CRM_STAT);
    chk("queued", 1, rd[1:0]);
    cmd(`TDC_OP_STOP, 1'b0);
    rdr(`TDC_CRM_STAT);
    chk("stop_queued", 0, rd[1:0]);
    wr(`TDC_CRM_CHNUM, 32'h0);
    cmd(`TDC_OP_STOP, 1'b0);
    rdr(`TDC_CRM_STAT);
    chk("stop_running", 2, rd[1:0]);
    wait_st(2'b00);
    chk("stop_acc", 1, nacc);
    rdr(`TDC_CRM_CTX);
    chk("ctx_locked", m_ctx, rd);
    delay = 4'h0;
    $display("test stop done");
    // Written-group tracking, full transfer and instruction TCM
    for (int i = 0; i < 5; i++) begin
      if (d_st[i] != 0)
        store(32'(d_st[i]));
      run(6'(d_f[i]), 12'h4, 2'h2, 16, 1'b0, 32'(d_o[i]));
      fin("dirty_acc", d_n[i], 2'h0);
    end
    $display("test dirty done");
    test_done();
  end

  // Whole run needs a few hundred cycles; this bound cuts a hang short
  initial begin
    #(30000 * 10);
    fails++;
    test_done();
  end
endmodule
